// >>> verilog/ocm_params.svh
// constants of the overcurrent trip monitor
`ifndef OCM_PARAMS_SVH
`define OCM_PARAMS_SVH

// ****************************************
// register map seen by the serial layer
// ****************************************
`define OCM_DATA_REG_ADDR 8'h00
`define OCM_CTRL_REG_ADDR 8'h06
`define OCM_CTRL_RESET 4'h0
`define OCM_CODE_MSB 3
`define OCM_CODE_LSB 0
`define OCM_CURRENT_MSB 8
`define OCM_CURRENT_LSB 0
`define OCM_SYNC_BIT 9
`define OCM_STICKY_BIT 10
`define OCM_LIVE_BIT 11

// ****************************************
// trip level table, percent of sensing range, code 15 first
// ****************************************
`define OCM_TRIP_PCT_TABLE {8'h92, 8'h8C, 8'h85, 8'h7F, 8'h78, 8'h72, 8'h6C, 8'h65, \
   8'h5F, 8'h58, 8'h52, 8'h4C, 8'h45, 8'h3F, 8'h38, 8'h32}
`define OCM_PCT_DIVISOR 100

// ****************************************
// timing
// ****************************************
`define OCM_CLK_PERIOD_NS 10
`define OCM_POWER_ON_TIME_NS 500000

`endif

// >>> verilog/ocm_pkg.sv
// types of the overcurrent trip monitor
package ocm_pkg;
   typedef enum logic [0:0]
   {
      OCM_ST_POWERUP = 1'b0,
      OCM_ST_RUN = 1'b1
   } ocm_state_t;
endpackage

// >>> verilog/ocm_trip_level.sv
// threshold code to trip level in measurement codes
`timescale 1ns/1ps
`include "ocm_params.svh"
module ocm_trip_level #(
   parameter int CurrWidth = 9,
   parameter int FullScale = 511
) (
   // threshold select
   input wire logic [3:0] thresholdCode,
   // trip level, one bit wider than a measurement to reach 146 percent
   output logic [CurrWidth:0] tripLevel
);
   localparam logic [127:0] PctTable = `OCM_TRIP_PCT_TABLE;

   function automatic logic [CurrWidth:0] levelOf(input logic [3:0] code);
      logic [31:0] prod;
      prod = 32'(PctTable[code * 8 +: 8]) * 32'(FullScale);
      return (CurrWidth + 1)'(prod / 32'(`OCM_PCT_DIVISOR));
   endfunction

   always_comb
   begin
      tripLevel = levelOf(thresholdCode);
   end
endmodule

// >>> verilog/ocm_monitor.sv
// overcurrent trip monitor core: trip level, alert pin, live and sticky flags
// Overview of operation
// - The trip level is derived from a four-bit threshold code, each code a fixed share of the sensing range.
// - Codes 0 to 15 give 50,56,63,69,76,82,88,95,101,108,114,120,127,133,140 and 146 percent of range.
// - The active-low alert pin is driven low while the current is above the trip level.
// - The alert pin is released once the current drops below the trip level.
// - The live flag is 1 while the current is above the level and 0 while it is below.
// - The sticky flag sets when the current is above the level and clears only on a write of 1 while below.
// - Measurement, both flags and the alert pin are invalid until the power-on time has elapsed.
// - The threshold code lives in bits 3:0 of the control register at 0x06, read/write, default 0.
// - The live flag is bit 11 and the sticky flag bit 10 of the 24-bit data register at 0x00.
`timescale 1ns/1ps
`include "ocm_params.svh"
module ocm_monitor #(
   parameter int CurrWidth = 9,
   parameter int FullScale = 511,
   parameter int PowerOnCycles = (`OCM_POWER_ON_TIME_NS + `OCM_CLK_PERIOD_NS - 1) / `OCM_CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // measurement from the converter
   input wire logic sampleValid,
   input wire logic [CurrWidth-1:0] sampleCode,
   // register actions decoded by the serial layer
   input wire logic ctrlWrite,
   input wire logic [7:0] ctrlWrData,
   input wire logic stickyClear,
   input wire logic dataRead,
   // register images
   output logic [7:0] ctrlRead,
   output logic [23:0] dataWord,
   // pin and status
   output logic alert_n,
   output logic liveFlag,
   output logic stickyFlag,
   output logic outputsValid
);
   localparam int CntWidth = $clog2(PowerOnCycles + 1);
   localparam logic [CntWidth-1:0] CntLast = CntWidth'(PowerOnCycles - 1);

   // ****************************************
   // power-on sequencing
   // ****************************************
   ocm_pkg::ocm_state_t state_q, state_d;
   logic [CntWidth-1:0] pwrCnt_q, pwrCnt_d;

   always_comb
   begin
      state_d = state_q;
      pwrCnt_d = pwrCnt_q;
      unique case (state_q)
         ocm_pkg::OCM_ST_POWERUP:
         begin
            if (pwrCnt_q == CntLast)
            begin
               state_d = ocm_pkg::OCM_ST_RUN;
            end
            else
            begin
               pwrCnt_d = pwrCnt_q + 1'b1;
            end
         end
         ocm_pkg::OCM_ST_RUN:
         begin
            pwrCnt_d = pwrCnt_q;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ocm_pkg::OCM_ST_POWERUP;
         pwrCnt_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         pwrCnt_q <= pwrCnt_d;
      end
   end

   wire logic running = (state_q == ocm_pkg::OCM_ST_RUN);

   // ****************************************
   // threshold control and trip level
   // ****************************************
   logic [3:0] code_q, code_d;
   logic [CurrWidth:0] level_q, level_d;
   logic [CurrWidth:0] tableLevel;

   ocm_trip_level #(
      .CurrWidth(CurrWidth),
      .FullScale(FullScale)
   ) u_level (
      .thresholdCode(code_q),
      .tripLevel(tableLevel)
   );

   always_comb
   begin
      code_d = code_q;
      if (ctrlWrite)
      begin
         code_d = ctrlWrData[`OCM_CODE_MSB:`OCM_CODE_LSB];
      end
      level_d = tableLevel;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code_q <= `OCM_CTRL_RESET;
         level_q <= '0;
      end
      else
      begin
         code_q <= code_d;
         level_q <= level_d;
      end
   end

   // ****************************************
   // measurement compare and flags
   // ****************************************
   logic [CurrWidth-1:0] curr_q, curr_d;
   logic live_q, live_d;
   logic sticky_q, sticky_d;
   logic sync_q, sync_d;
   logic alertN_q, alertN_d;
   logic [23:0] data_q, data_d;
   logic [7:0] ctrlImg_q, ctrlImg_d;
   logic above;
   logic below;

   always_comb
   begin
      above = {1'b0, curr_q} > level_q;
      below = {1'b0, curr_q} < level_q;
      curr_d = curr_q;
      live_d = live_q;
      sticky_d = sticky_q;
      sync_d = sync_q;
      if (running)
      begin
         if (sampleValid)
         begin
            curr_d = sampleCode;
         end
         if (above)
         begin
            live_d = 1'b1;
         end
         else if (below)
         begin
            live_d = 1'b0;
         end
         // sticky clear only below, set wins
         if (stickyClear && below)
         begin
            sticky_d = 1'b0;
         end
         if (above)
         begin
            sticky_d = 1'b1;
         end
         // new data outranks a read in the same cycle
         if (dataRead)
         begin
            sync_d = 1'b0;
         end
         if (sampleValid)
         begin
            sync_d = 1'b1;
         end
      end
      alertN_d = !live_d;
      data_d = '0;
      data_d[`OCM_CURRENT_MSB:`OCM_CURRENT_LSB] = 9'(curr_d);
      data_d[`OCM_SYNC_BIT] = sync_d;
      data_d[`OCM_STICKY_BIT] = sticky_d;
      data_d[`OCM_LIVE_BIT] = live_d;
      ctrlImg_d = {4'h0, code_d};
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         curr_q <= '0;
         live_q <= 1'b0;
         sticky_q <= 1'b0;
         sync_q <= 1'b0;
         alertN_q <= 1'b1;
         data_q <= 24'h000000;
         ctrlImg_q <= 8'h00;
      end
      else
      begin
         curr_q <= curr_d;
         live_q <= live_d;
         sticky_q <= sticky_d;
         sync_q <= sync_d;
         alertN_q <= alertN_d;
         data_q <= data_d;
         ctrlImg_q <= ctrlImg_d;
      end
   end

   assign alert_n = alertN_q;
   assign liveFlag = live_q;
   assign stickyFlag = sticky_q;
   assign dataWord = data_q;
   assign ctrlRead = ctrlImg_q;
   assign outputsValid = state_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // level register lags the code by one cycle, also right after reset
   sequence s_codeSteady;
      code_q == 4'h0 [*3];
   endsequence

   a_level_from_code: assert property (s_codeSteady |-> level_q == (CurrWidth + 1)'(FullScale * 50 / 100))
      else $error("trip level does not match code 0");
   a_alert_tracks_live: assert property (alert_n == !liveFlag)
      else $error("alert pin disagrees with live flag");
   a_live_sets_above: assert property (running && above |=> liveFlag && !alert_n)
      else $error("live flag or alert not set above level");
   a_live_clears_below: assert property (running && below |=> !liveFlag && alert_n)
      else $error("live flag or alert not cleared below level");
   a_equal_holds: assert property (running && !above && !below |=> $stable(liveFlag))
      else $error("live flag moved at equal level");
   a_sticky_hold: assert property (stickyFlag && !(stickyClear && below) |=> stickyFlag)
      else $error("sticky flag dropped without valid clear");
   a_sticky_set: assert property (running && above |=> stickyFlag)
      else $error("sticky flag not set above level");
   a_powerup_quiet: assert property (!running |=> !liveFlag && !stickyFlag && alert_n && dataWord == 24'h000000)
      else $error("outputs active before power-on time");
   a_powerup_time: assert property ($rose(state_q) |-> $past(pwrCnt_q) == CntLast)
      else $error("power-on time count wrong");
   a_ctrl_write: assert property (ctrlWrite |=> code_q == $past(ctrlWrData[3:0]) ##1 ctrlRead[3:0] == code_q)
      else $error("control write not taken");
   a_data_layout: assert property (dataWord[11] == liveFlag && dataWord[10] == stickyFlag && dataWord[23:12] == 12'h000)
      else $error("data register layout wrong");
endmodule

// >>> test/ocm_host_model.sv
// host controller model issuing register strobes
`timescale 1ns/1ps
module ocm_host_model (
   // clock
   input wire logic core_clk,
   // register strobes
   output logic ctrlWrite,
   output logic [7:0] ctrlWrData,
   output logic stickyClear,
   output logic dataRead
);
   initial
   begin
      ctrlWrite = 1'b0;
      ctrlWrData = 8'h00;
      stickyClear = 1'b0;
      dataRead = 1'b0;
   end
   task automatic write_code(input logic [3:0] code);
      @(posedge core_clk);
      ctrlWrite <= 1'b1;
      ctrlWrData <= {4'hA, code};
      @(posedge core_clk);
      ctrlWrite <= 1'b0;
      // released bus shows the inverse, not a stale value
      ctrlWrData <= ~{4'hA, code};
   endtask
   task automatic strobe(input logic clr);
      @(posedge core_clk);
      stickyClear <= clr;
      dataRead <= ~clr;
      @(posedge core_clk);
      stickyClear <= 1'b0;
      dataRead <= 1'b0;
   endtask
   function automatic int to_milliamps(input logic [8:0] code, input int resMa);
      return code * resMa;
   endfunction
endmodule

// >>> test/tb_top.sv
// self-checking bench of the overcurrent trip monitor
`timescale 1ns/1ps
module tb_top;
   localparam int Pct [16] = '{50, 56, 63, 69, 76, 82, 88, 95, 101, 108, 114, 120, 127, 133, 140, 146};
   logic core_clk, rst_n, sampleValid, ctrlWrite, stickyClear, dataRead;
   logic alert_n, liveFlag, stickyFlag, outputsValid;
   logic [8:0] sampleCode;
   logic [7:0] ctrlWrData, ctrlRead;
   logic [23:0] dataWord;
   int fails = 0;
   int comparisons = 0;

   // short power-on count keeps the run brief
   ocm_monitor #(.PowerOnCycles(20)) ocm_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
      .sampleValid(sampleValid), .sampleCode(sampleCode), .ctrlWrite(ctrlWrite), .ctrlWrData(ctrlWrData),
      .stickyClear(stickyClear), .dataRead(dataRead), .ctrlRead(ctrlRead), .dataWord(dataWord),
      .alert_n(alert_n), .liveFlag(liveFlag), .stickyFlag(stickyFlag), .outputsValid(outputsValid));
   ocm_host_model ocm_host_model_i (.core_clk(core_clk), .ctrlWrite(ctrlWrite), .ctrlWrData(ctrlWrData),
      .stickyClear(stickyClear), .dataRead(dataRead));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk_out(input logic live, input logic sticky);
      chk({alert_n, liveFlag, stickyFlag, dataWord[11:10]}, {~live, live, sticky, live, sticky});
   endtask

   task automatic report_and_stop();
      if (fails == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic feed(input logic [8:0] code);
      @(posedge core_clk);
      sampleValid <= 1'b1;
      sampleCode <= code;
      @(posedge core_clk);
      sampleValid <= 1'b0;
      sampleCode <= ~code;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic test_power_on();
      int n;
      chk(ctrlRead, 24'h0);
      feed(9'h1FF);
      chk(dataWord, 24'h000000);
      chk({23'h000000, outputsValid}, 24'h000000);
      chk_out(1'b0, 1'b0);
      n = 0;
      while (outputsValid !== 1'b1 && n < 100)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 100)
      begin
         fails++;
         report_and_stop();
      end
   endtask

   task automatic test_levels();
      int lvl;
      for (int c = 0; c < 16; c++)
      begin
         lvl = Pct[c] * 511 / 100;
         ocm_host_model_i.write_code(c[3:0]);
         #1;
         chk(ctrlRead, {16'h0, 4'h0, c[3:0]});
         if (lvl < 511)
         begin
            feed(lvl[8:0] + 9'h1);
            chk_out(1'b1, 1'b1);
            chk(dataWord[9:0], {1'b1, lvl[8:0] + 9'h1});
            feed(lvl[8:0]);
            chk_out(1'b1, 1'b1);
            feed(lvl[8:0] - 9'h1);
            chk_out(1'b0, 1'b1);
            feed(lvl[8:0]);
            chk_out(1'b0, 1'b1);
            ocm_host_model_i.strobe(1'b1);
            #1;
            chk_out(1'b0, 1'b1);
            feed(lvl[8:0] - 9'h1);
            ocm_host_model_i.strobe(1'b1);
            #1;
            chk_out(1'b0, 1'b0);
         end
         else
         begin
            feed(9'h1FF);
            chk_out(1'b0, 1'b0);
         end
      end
   endtask

   task automatic test_sticky_hold();
      ocm_host_model_i.write_code(4'h0);
      feed(9'h12C);
      ocm_host_model_i.strobe(1'b1);
      #1;
      chk_out(1'b1, 1'b1);
      ocm_host_model_i.strobe(1'b0);
      #1;
      chk(dataWord[9:0], 10'h12C);
      chk(24'(ocm_host_model_i.to_milliamps(dataWord[8:0], 25)), 24'h001D4C);
      feed(9'h064);
      chk_out(1'b0, 1'b1);
      chk(dataWord[23:12], 24'h0);
   endtask

   initial
   begin
      rst_n = 1'b0;
      sampleValid = 1'b0;
      sampleCode = 9'h000;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      test_power_on();
      test_levels();
      test_sticky_hold();
      report_and_stop();
   end
endmodule
